// File: core/sacb_pkg.sv
// shared constants, field layout and carrier types of the shunt converter b configuration block
// assumes one core clock domain and a sixteen-bit register word with an eight-bit address
package sacb_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] SACB_ADDR_CONV = 8'hC2; // shunt_b_conversion_config
	localparam logic [7:0] SACB_ADDR_INPUT = 8'hC3; // shunt_b_input_config
	localparam logic [7:0] SACB_ADDR_OFS_UPPER = 8'hC4; // shunt_b_offset_upper
	localparam logic [7:0] SACB_ADDR_OFS_LOWER = 8'hC5; // lower offset byte, upper half of word

	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [15:0] SACB_RST_CONV = 16'h0400; // osr code 100, continuous, chop off
	localparam logic [15:0] SACB_RST_INPUT = 16'h8010; // enabled, sink on negative pin
	localparam logic [15:0] SACB_RST_OFS_UPPER = 16'h0000; // zero offset
	localparam logic [7:0] SACB_RST_OFS_LOWER = 8'h00; // zero offset low byte
	localparam logic [15:0] SACB_WMASK_CONV = 16'h0F0F; // bits 15:12 and 7:4 read-only
	localparam logic [15:0] SACB_WMASK_INPUT = 16'h8F3F; // bits 14:12 and 7:6 read-only
	localparam logic [15:0] SACB_WMASK_OFS_UPPER = 16'hFFFF; // all bits writable

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SACB_CONV_MODE_BIT = 11; // single-shot when set
	localparam int SACB_OSR_LSB = 8; // three-bit ratio code
	localparam int SACB_GC_EN_BIT = 3; // global chop on
	localparam int SACB_GC_DLY_LSB = 0; // three-bit chop delay code
	localparam int SACB_EN_BIT = 15; // converter enable
	localparam int SACB_GAIN_LSB = 10; // two-bit gain code
	localparam int SACB_MUX_LSB = 8; // two-bit input mux code
	localparam int SACB_SRC_ROUTE_BIT = 5; // source on negative pin when set
	localparam int SACB_SINK_ROUTE_BIT = 4; // sink on negative pin when set
	localparam int SACB_SRC_LVL_LSB = 2; // source magnitude code
	localparam int SACB_SINK_LVL_LSB = 0; // sink magnitude code
	localparam int SACB_OFS_LOWER_LSB = 8; // low offset byte sits in bits 15:8

	// ----------------------------------------------------------------
	// timing and scaling bases
	// ----------------------------------------------------------------
	localparam logic [13:0] SACB_OSR_BASE = 14'h0040; // ratio for code 000
	localparam logic [8:0] SACB_GC_DLY_BASE = 9'h002; // modulator periods for code 000
	localparam logic [5:0] SACB_GAIN_BASE = 6'h04; // total gain for code 00
	localparam logic [3:0] SACB_ANALOG_GAIN_LO = 4'h4; // analog stage at gain 4
	localparam logic [3:0] SACB_ANALOG_GAIN_HI = 4'h8; // analog stage cap for 8, 16, 32

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SACB_MUX_DIRECT = 2'h0, // positive pin to positive input
		SACB_MUX_SWAP = 2'h1, // pins swapped
		SACB_MUX_SHORT = 2'h2, // inputs shorted to analog ground
		SACB_MUX_TESTDAC = 2'h3 // test dac routed in
	} sacb_mux_t;

	typedef struct packed {
		logic [15:0] conv; // conversion config word
		logic [15:0] inputCfg; // input config word
		logic [15:0] ofsUpper; // offset bits 23:8
		logic [7:0] ofsLower; // offset bits 7:0
	} sacb_regs_t;

	typedef struct packed {
		logic convModeSingle; // single-shot mode selected
		logic [13:0] osrRatio; // oversampling ratio 64..8192
		logic gcEnable; // global chop on
		logic [8:0] gcDelayCycles; // chop settling delay in modulator periods
		logic convEnable; // converter enabled
		logic [5:0] gainTotal; // total gain 4..32
		logic [3:0] analogGain; // analog stage gain 4 or 8
		logic [1:0] digitalShift; // remaining digital factor as shift
		logic muxDirect; // one-hot input mux selects
		logic muxSwap;
		logic muxShort;
		logic muxTestDac;
		logic srcOnNeg; // open-wire source on negative pin
		logic sinkOnNeg; // open-wire sink on negative pin
		logic [1:0] srcLevel; // source magnitude code
		logic [1:0] sinkLevel; // sink magnitude code
		logic [23:0] offsetCal; // two's complement offset, lsb scales with gain
		logic clearResult; // result and counter held at zero
	} sacb_drive_t;

	typedef struct packed {
		logic [23:0] data; // latest conversion result
		logic [1:0] count; // conversion counter
		logic valid; // one-cycle pulse on new result
	} sacb_result_t;

	// ----------------------------------------------------------------
	// decode of the register words into datapath controls
	// ----------------------------------------------------------------
	function automatic sacb_drive_t sacb_decode(input sacb_regs_t r);
		sacb_drive_t d;
		logic [1:0] g;
		logic [1:0] m;
		d = '0;
		g = r.inputCfg[SACB_GAIN_LSB +: 2];
		m = r.inputCfg[SACB_MUX_LSB +: 2];
		d.convModeSingle = r.conv[SACB_CONV_MODE_BIT];
		d.osrRatio = SACB_OSR_BASE << r.conv[SACB_OSR_LSB +: 3];
		d.gcEnable = r.conv[SACB_GC_EN_BIT];
		d.gcDelayCycles = SACB_GC_DLY_BASE << r.conv[SACB_GC_DLY_LSB +: 3];
		d.convEnable = r.inputCfg[SACB_EN_BIT];
		d.gainTotal = SACB_GAIN_BASE << g;
		d.analogGain = (g == 2'h0) ? SACB_ANALOG_GAIN_LO : SACB_ANALOG_GAIN_HI;
		d.digitalShift = (g[1]) ? ((g[0]) ? 2'h2 : 2'h1) : 2'h0;
		d.muxDirect = (m == SACB_MUX_DIRECT);
		d.muxSwap = (m == SACB_MUX_SWAP);
		d.muxShort = (m == SACB_MUX_SHORT);
		d.muxTestDac = (m == SACB_MUX_TESTDAC);
		d.srcOnNeg = r.inputCfg[SACB_SRC_ROUTE_BIT];
		d.sinkOnNeg = r.inputCfg[SACB_SINK_ROUTE_BIT];
		d.srcLevel = r.inputCfg[SACB_SRC_LVL_LSB +: 2];
		d.sinkLevel = r.inputCfg[SACB_SINK_LVL_LSB +: 2];
		d.offsetCal = {r.ofsUpper, r.ofsLower};
		return d;
	endfunction : sacb_decode

endpackage : sacb_pkg

// File: core/sacb_result_hold.sv
// conversion result holder with its two-bit conversion counter
// assumes data and clear come from logic on the same core clock
`timescale 1ns/1ps
module sacb_result_hold (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clearReq,
	input wire logic dataValid,
	input wire logic [23:0] dataIn,
	output sacb_pkg::sacb_result_t result
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sacb_pkg::sacb_result_t hold_ff; // whole state of this module
	sacb_pkg::sacb_result_t nxt_hold; // next value

	// capture, count and forced clear
	always_comb begin
		nxt_hold = hold_ff;
		nxt_hold.valid = 1'b0;
		if (clearReq) begin
			// clear wins over an arriving result
			nxt_hold.data = 24'h000000;
			nxt_hold.count = 2'h0;
		end else if (dataValid) begin
			// new result, counter wraps modulo four
			nxt_hold.data = dataIn;
			nxt_hold.count = 2'(hold_ff.count + 2'h1);
			nxt_hold.valid = 1'b1;
		end
	end

	// register, frozen while ce is low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_ff <= '0;
		end else if (ce) begin
			hold_ff <= nxt_hold;
		end
	end

	assign result = hold_ff;

endmodule : sacb_result_hold

// File: core/sacb_config_regs.sv
// configuration registers of shunt converter b and the decoded datapath controls
// assumes a register port on the core clock, one access per cycle, and same-clock datapath inputs
`timescale 1ns/1ps

module sacb_config_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic standbyReq,
	input wire logic convDataValid,
	input wire logic [23:0] convDataIn,
	output logic [15:0] regRdData,
	output sacb_pkg::sacb_drive_t driveOut,
	output sacb_pkg::sacb_result_t resultOut
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------

	// state of this module in one word, apart from the result holder's
	typedef struct packed {
		sacb_pkg::sacb_regs_t regs; // register words, unused bits held at zero
		logic [15:0] rdData; // registered read data
		sacb_pkg::sacb_drive_t drive; // decoded datapath controls
	} sacb_state_t;

	sacb_state_t st_ff; // registered state
	sacb_state_t nxt_st; // next state

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------

	// register writes, reads and control decode
	always_comb begin
		nxt_st = st_ff;
		if (rst) begin
			// reset words, controls decoded from them
			nxt_st.regs.conv = sacb_pkg::SACB_RST_CONV;
			nxt_st.regs.inputCfg = sacb_pkg::SACB_RST_INPUT;
			nxt_st.regs.ofsUpper = sacb_pkg::SACB_RST_OFS_UPPER;
			nxt_st.regs.ofsLower = sacb_pkg::SACB_RST_OFS_LOWER;
			nxt_st.rdData = 16'h0000;
		end else begin
			// write path, unused bits masked off
			if (regWrEn) begin
				if (regAddr == sacb_pkg::SACB_ADDR_CONV) begin
					// mode, ratio, chop enable and delay
					nxt_st.regs.conv = regWrData & sacb_pkg::SACB_WMASK_CONV;
				end else if (regAddr == sacb_pkg::SACB_ADDR_INPUT) begin
					// enable, gain, mux and open-wire fields
					nxt_st.regs.inputCfg = regWrData & sacb_pkg::SACB_WMASK_INPUT;
				end else if (regAddr == sacb_pkg::SACB_ADDR_OFS_UPPER) begin
					// offset bits 23:8
					nxt_st.regs.ofsUpper = regWrData & sacb_pkg::SACB_WMASK_OFS_UPPER;
				end else if (regAddr == sacb_pkg::SACB_ADDR_OFS_LOWER) begin
					// offset bits 7:0 from the upper byte only
					nxt_st.regs.ofsLower = regWrData[sacb_pkg::SACB_OFS_LOWER_LSB +: 8];
				end
			end
			// read path, old value on a same-cycle write
			if (regRdEn) begin
				if (regAddr == sacb_pkg::SACB_ADDR_CONV) begin
					// reserved bits already zero in the stored word
					nxt_st.rdData = st_ff.regs.conv;
				end else if (regAddr == sacb_pkg::SACB_ADDR_INPUT) begin
					// reserved bits already zero in the stored word
					nxt_st.rdData = st_ff.regs.inputCfg;
				end else if (regAddr == sacb_pkg::SACB_ADDR_OFS_UPPER) begin
					// full word
					nxt_st.rdData = st_ff.regs.ofsUpper;
				end else if (regAddr == sacb_pkg::SACB_ADDR_OFS_LOWER) begin
					// low byte of this word reads zero
					nxt_st.rdData = {st_ff.regs.ofsLower, 8'h00};
				end else begin
					// unmapped address reads zero
					nxt_st.rdData = 16'h0000;
				end
			end
		end
		// controls follow the new words in the same edge
		nxt_st.drive = sacb_pkg::sacb_decode(nxt_st.regs);
		// disabled or standby holds the result cleared
		nxt_st.drive.clearResult = ~nxt_st.drive.convEnable | (standbyReq & ~rst);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------

	// sync reset overrides the clock enable
	always_ff @(posedge core_clk) begin
		if (rst || ce) begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// result holder
	// ----------------------------------------------------------------

	// result and counter cleared on the registered clear
	sacb_result_hold u_result (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.clearReq(st_ff.drive.clearResult),
		.dataValid(convDataValid),
		.dataIn(convDataIn),
		.result(resultOut)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// all outputs are flip-flop values
	assign regRdData = st_ff.rdData;
	assign driveOut = st_ff.drive;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------

	default clocking cbAsrt @(posedge core_clk);
	endclocking

	default disable iff (rst);

	// write to the conversion word, taken
	sequence sWrConv;
		ce && regWrEn && (regAddr == sacb_pkg::SACB_ADDR_CONV);
	endsequence

	// write to the input word, taken
	sequence sWrInput;
		ce && regWrEn && (regAddr == sacb_pkg::SACB_ADDR_INPUT);
	endsequence

	// read of the conversion word, taken
	sequence sRdConv;
		ce && regRdEn && (regAddr == sacb_pkg::SACB_ADDR_CONV);
	endsequence

	// read of the input word, taken
	sequence sRdInput;
		ce && regRdEn && (regAddr == sacb_pkg::SACB_ADDR_INPUT);
	endsequence

	// write to the upper offset word, taken
	sequence sWrUpper;
		ce && regWrEn && (regAddr == sacb_pkg::SACB_ADDR_OFS_UPPER);
	endsequence

	// read of the upper offset word, taken
	sequence sRdUpper;
		ce && regRdEn && (regAddr == sacb_pkg::SACB_ADDR_OFS_UPPER);
	endsequence

	// result taken by the holder
	sequence sResTaken;
		ce && convDataValid && !driveOut.clearResult;
	endsequence

	// mode bit follows the written value
	a_mode_select: assert property (
		sWrConv |=> (driveOut.convModeSingle == $past(regWrData[11])))
		else $error("conversion mode does not follow write");

	// ratio is 64 shifted by the code
	a_osr_decode: assert property (
		sWrConv |=> (driveOut.osrRatio == (14'h0040 << $past(regWrData[10:8]))))
		else $error("oversampling ratio decode wrong");

	// ratio is 1024 right after reset
	a_osr_reset: assert property (
		$fell(rst) |-> (driveOut.osrRatio == 14'h0400) && !driveOut.gcEnable)
		else $error("oversampling ratio reset value wrong");

	// chop enable and delay follow the write
	a_chop_delay: assert property (
		sWrConv |=> (driveOut.gcEnable == $past(regWrData[3]))
			&& (driveOut.gcDelayCycles == (9'h002 << $past(regWrData[2:0]))))
		else $error("global chop decode wrong");

	// disabled converter holds result and counter at zero
	a_disable_clear: assert property (
		(ce && driveOut.clearResult) |=> (resultOut.data == 24'h000000)
			&& (resultOut.count == 2'h0) && !resultOut.valid)
		else $error("result not cleared while disabled");

	// standby raises the clear on the next edge
	a_standby_clear: assert property (
		(ce && standbyReq) |=> driveOut.clearResult)
		else $error("standby does not clear the result");

	// gain 32 uses analog 8 and a digital shift of two
	a_gain_split: assert property (
		sWrInput ##0 (regWrData[11:10] == 2'h3) |=> (driveOut.analogGain == 4'h8)
			&& (driveOut.digitalShift == 2'h2) && (driveOut.gainTotal == 6'h20))
		else $error("gain split wrong for gain 32");

	// exactly one input mux path is active
	a_mux_onehot: assert property (
		$onehot({driveOut.muxDirect, driveOut.muxSwap, driveOut.muxShort, driveOut.muxTestDac}))
		else $error("input mux select not one-hot");

	// reserved bits of the conversion word read zero
	a_reserved_zero: assert property (
		sRdConv |=> (regRdData[15:12] == 4'h0) && (regRdData[7:4] == 4'h0))
		else $error("reserved bits read nonzero");

	// writes to unused bits leave neighbours and read zero
	a_write_mask: assert property (
		sWrInput ##1 !regWrEn ##1 sRdInput
			|=> (regRdData == ($past(regWrData, 3) & 16'h8F3F)))
		else $error("input word masking wrong");

	// offset bits 7:0 follow the upper byte of a low byte write
	a_offset_store: assert property (
		(ce && regWrEn && (regAddr == sacb_pkg::SACB_ADDR_OFS_LOWER))
			|=> (driveOut.offsetCal[7:0] == $past(regWrData[15:8])))
		else $error("low offset byte not stored");

	// open-wire routing and levels follow the write
	a_openwire_cfg: assert property (
		sWrInput |=> (driveOut.srcLevel == $past(regWrData[3:2]))
			&& (driveOut.sinkLevel == $past(regWrData[1:0]))
			&& (driveOut.srcOnNeg == $past(regWrData[5]))
			&& (driveOut.sinkOnNeg == $past(regWrData[4])))
		else $error("open-wire settings not applied");

	// reset leaves continuous mode, enabled, direct input
	a_mode_reset: assert property (
		$fell(rst) |-> !driveOut.convModeSingle && driveOut.convEnable && driveOut.muxDirect)
		else $error("mode or enable reset value wrong");

	// chop off with the shortest delay after reset
	a_chop_reset: assert property (
		$fell(rst) |-> !driveOut.gcEnable && (driveOut.gcDelayCycles == 9'h002))
		else $error("global chop reset state wrong");

	// total gain is four shifted by the code
	a_gain_decode: assert property (
		sWrInput |=> (driveOut.gainTotal == (6'h04 << $past(regWrData[11:10]))))
		else $error("gain decode wrong");

	// gain four at reset, all analog
	a_gain_reset: assert property (
		$fell(rst) |-> (driveOut.gainTotal == 6'h04) && (driveOut.analogGain == 4'h4)
			&& (driveOut.digitalShift == 2'h0))
		else $error("gain reset value wrong");

	// gain 16 uses analog 8 and one digital doubling
	a_gain_sixteen: assert property (
		sWrInput ##0 (regWrData[11:10] == 2'h2) |=> (driveOut.analogGain == 4'h8)
			&& (driveOut.digitalShift == 2'h1))
		else $error("gain split wrong for gain 16");

	// direct and swapped paths follow the mux code
	a_mux_pins: assert property (
		sWrInput |=> (driveOut.muxDirect == ($past(regWrData[9:8]) == 2'h0))
			&& (driveOut.muxSwap == ($past(regWrData[9:8]) == 2'h1)))
		else $error("direct or swapped input path wrong");

	// ground short and test dac follow the mux code
	a_mux_internal: assert property (
		sWrInput |=> (driveOut.muxShort == ($past(regWrData[9:8]) == 2'h2))
			&& (driveOut.muxTestDac == ($past(regWrData[9:8]) == 2'h3)))
		else $error("short or test dac path wrong");

	// source starts on the positive pin, switched off
	a_source_reset: assert property (
		$fell(rst) |-> !driveOut.srcOnNeg && (driveOut.srcLevel == 2'h0))
		else $error("open-wire source reset state wrong");

	// sink starts on the negative pin, switched off
	a_sink_reset: assert property (
		$fell(rst) |-> driveOut.sinkOnNeg && (driveOut.sinkLevel == 2'h0))
		else $error("open-wire sink reset state wrong");

	// upper offset word lands in bits 23:8
	a_offset_upper: assert property (
		sWrUpper |=> (driveOut.offsetCal[23:8] == $past(regWrData)))
		else $error("upper offset word not stored");

	// offset is zero after reset
	a_offset_reset: assert property (
		$fell(rst) |-> (driveOut.offsetCal == 24'h000000))
		else $error("offset reset value wrong");

	// upper offset word reads back as stored
	a_offset_read: assert property (
		sRdUpper |=> (regRdData == $past(driveOut.offsetCal[23:8])))
		else $error("upper offset read-back wrong");

	// offset scaling sees total gain as analog times digital
	a_gain_product: assert property (
		driveOut.gainTotal == ({2'h0, driveOut.analogGain} << driveOut.digitalShift))
		else $error("exported total gain inconsistent");

	// reserved bits of the input word read zero
	a_reserved_input: assert property (
		sRdInput |=> (regRdData[14:12] == 3'h0) && (regRdData[7:6] == 2'h0))
		else $error("input word reserved bits read nonzero");

	// unmapped addresses read zero
	a_unmapped_read: assert property (
		(ce && regRdEn && ((regAddr < 8'hC2) || (regAddr > 8'hC5)))
			|=> (regRdData == 16'h0000))
		else $error("unmapped read not zero");

	// low offset byte reads in the upper half only
	a_lower_read: assert property (
		(ce && regRdEn && (regAddr == sacb_pkg::SACB_ADDR_OFS_LOWER))
			|=> (regRdData == {$past(driveOut.offsetCal[7:0]), 8'h00}))
		else $error("low offset byte read-back wrong");

	// low clock enable freezes controls, read data and result
	a_ce_freeze: assert property (
		!ce |=> $stable(driveOut) && $stable(regRdData) && $stable(resultOut))
		else $error("state moved while clock enable low");

	// a taken result advances the counter by one
	a_count_step: assert property (
		sResTaken |=> resultOut.valid && (resultOut.count == 2'($past(resultOut.count) + 2'h1)))
		else $error("conversion counter step wrong");

	// valid pulses only after a taken result
	a_valid_source: assert property (
		resultOut.valid && $past(ce) |-> $past(convDataValid && !driveOut.clearResult))
		else $error("result valid without a taken result");

endmodule : sacb_config_regs

// File: sim/sacb_config_regs_tb.sv
// self-checking bench for the shunt converter b configuration registers
// assumes the package is compiled first and the block has no parameters
`timescale 1ns/1ps
module sacb_config_regs_tb;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic core_clk = 1'b0; // 20 MHz core clock
	logic rst = 1'b1; // synchronous reset, high at start
	logic ce = 1'b1; // clock enable
	logic [7:0] regAddr = 8'h00; // register address
	logic [15:0] regWrData = 16'h0000; // write data
	logic regWrEn = 1'b0; // write strobe
	logic regRdEn = 1'b0; // read strobe
	logic standbyReq = 1'b0; // standby indication
	logic convDataValid = 1'b0; // result strobe from filter
	logic [23:0] convDataIn = 24'h000000; // result from filter
	logic [15:0] regRdData; // read data
	sacb_pkg::sacb_drive_t drv; // decoded controls
	sacb_pkg::sacb_result_t res; // held result
	int numErrors = 0; // mismatches seen
	int cmpCount = 0; // comparisons made
	logic [15:0] rdv; // last value read

	sacb_config_regs dut (.core_clk(core_clk), .rst(rst), .ce(ce), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .standbyReq(standbyReq),
		.convDataValid(convDataValid), .convDataIn(convDataIn), .regRdData(regRdData),
		.driveOut(drv), .resultOut(res));

	// clock: invert every half period of 25 ns
	always #25 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	// compare seen against expected, report and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one write cycle, controls visible on return
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge core_clk);
		regWrEn = 1'b0;
	endtask : wr

	// one read cycle, data taken the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge core_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge core_clk);
		regRdEn = 1'b0;
		d = regRdData;
	endtask : rd

	// one result from the filter, checked on the valid cycle
	task automatic push(input logic [23:0] v, input logic [23:0] expData, input logic [1:0] expCnt);
		@(negedge core_clk);
		convDataIn = v;
		convDataValid = 1'b1;
		@(negedge core_clk);
		convDataValid = 1'b0;
		check(32'(res.data), 32'(expData));
		check(32'(res.count), 32'(expCnt));
	endtask : push

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset words and their decode
	task automatic testReset();
		rd(8'hC2, rdv);
		check(32'(rdv), 32'h0400);
		rd(8'hC3, rdv);
		check(32'(rdv), 32'h8010);
		rd(8'hC4, rdv);
		check(32'(rdv), 32'h0000);
		rd(8'hC5, rdv);
		check(32'(rdv), 32'h0000);
		check(32'(drv.osrRatio), 32'd1024);
		check(32'({drv.convModeSingle, drv.gcEnable}), 32'h0);
		check(32'(drv.gcDelayCycles), 32'd2);
		check(32'({drv.convEnable, drv.clearResult}), 32'h2);
		check(32'(drv.gainTotal), 32'd4);
		check(32'({drv.srcOnNeg, drv.sinkOnNeg, drv.srcLevel, drv.sinkLevel}), 32'h10);
		check(32'(drv.muxDirect), 32'h1);
	endtask : testReset

	// every ratio and delay code, mode and chop toggled
	task automatic testConv();
		logic [15:0] w;
		for (int i = 0; i < 8; i++) begin
			w = {4'h0, i[0], 3'(i), 4'h0, i[1], 3'(i)};
			wr(8'hC2, w);
			check(32'(drv.osrRatio), 32'h40 << i);
			check(32'(drv.convModeSingle), 32'(i[0]));
			check(32'(drv.gcEnable), 32'(i[1]));
			check(32'(drv.gcDelayCycles), 32'h2 << i);
		end
	endtask : testConv

	// all ones into the conversion and input words, reserved bits stay zero
	task automatic testReserved();
		wr(8'hC2, 16'hFFFF);
		rd(8'hC2, rdv);
		check(32'(rdv), 32'h0F0F);
		wr(8'hC3, 16'hFFFF);
		rd(8'hC3, rdv);
		check(32'(rdv), 32'h8F3F);
		wr(8'hC3, 16'h7000);
		rd(8'hC3, rdv);
		check(32'(rdv), 32'h0000);
		wr(8'hC3, 16'h8010);
	endtask : testReserved

	// gain, mux and open-wire codes
	task automatic testInput();
		logic [15:0] w;
		for (int i = 0; i < 4; i++) begin
			w = {1'b1, 3'h0, 2'(i), 2'(i), 2'h0, i[0], ~i[0], 2'(i), 2'(3 - i)};
			wr(8'hC3, w);
			check(32'(drv.gainTotal), 32'h4 << i);
			check(32'(drv.analogGain), (i == 0) ? 32'h4 : 32'h8);
			check(32'(drv.digitalShift), (i < 2) ? 32'h0 : 32'(i - 1));
			check(32'({drv.muxTestDac, drv.muxShort, drv.muxSwap, drv.muxDirect}),
				32'h1 << i);
			check(32'({drv.srcOnNeg, drv.sinkOnNeg}), 32'({i[0], ~i[0]}));
			check(32'(drv.srcLevel), 32'(i));
			check(32'(drv.sinkLevel), 32'(3 - i));
		end
	endtask : testInput

	// offset halves, negative value, scaling input exported
	task automatic testOffset();
		wr(8'hC4, 16'h8001);
		wr(8'hC5, 16'hA55A);
		check(32'(drv.offsetCal), 32'h8001A5);
		rd(8'hC5, rdv);
		check(32'(rdv), 32'hA500);
		check(32'(drv.gainTotal), 32'd32);
	endtask : testOffset

	// results, disable forcing and standby clearing
	task automatic testResult();
		wr(8'hC3, 16'h8010);
		push(24'h123456, 24'h123456, 2'h1);
		check(32'(res.valid), 32'h1);
		@(negedge core_clk);
		check(32'(res.valid), 32'h0);
		wr(8'hC3, 16'h0010);
		@(negedge core_clk);
		check(32'(drv.clearResult), 32'h1);
		push(24'hABCDEF, 24'h000000, 2'h0);
		wr(8'hC3, 16'h8010);
		@(negedge core_clk);
		push(24'h000011, 24'h000011, 2'h1);
		push(24'hFFFFFF, 24'hFFFFFF, 2'h2);
		standbyReq = 1'b1;
		repeat (2) @(negedge core_clk);
		check(32'({res.data, res.count}), 32'h0);
		standbyReq = 1'b0;
	endtask : testResult

	// unmapped place and frozen clock enable
	task automatic testRefused();
		wr(8'h10, 16'hFFFF);
		rd(8'h10, rdv);
		check(32'(rdv), 32'h0000);
		@(negedge core_clk);
		ce = 1'b0;
		wr(8'hC4, 16'h1234);
		ce = 1'b1;
		rd(8'hC4, rdv);
		check(32'(rdv), 32'h8001);
	endtask : testRefused

	// ----------------------------------------------------------------
	// verdict and run control
	// ----------------------------------------------------------------
	// counts, verdict and end of run
	task automatic closeOut();
		$display("comparisons %0d mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : closeOut

	// watchdog well beyond the fewer than one hundred cycles needed
	initial begin
		#(2000 * 50);
		numErrors++;
		closeOut();
	end

	// main sequence
	initial begin
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		testReset();
		testConv();
		testReserved();
		testInput();
		testOffset();
		testResult();
		testRefused();
		closeOut();
	end
endmodule : sacb_config_regs_tb
